// ==== core/tep_pkg.sv ====
package tep_pkg;

  // ----------------------------------------------------------------------
  // Register map, byte addresses on the bus.
  // ----------------------------------------------------------------------
  localparam int TEP_ADR_W = 5;
  localparam logic [4:0] TEP_CTRL_OFS = 5'h00;
  localparam logic [4:0] TEP_T0_OFS = 5'h04;
  localparam logic [4:0] TEP_T1_OFS = 5'h08;
  localparam logic [4:0] TEP_T2_OFS = 5'h0C;
  localparam logic [4:0] TEP_RLD_OFS = 5'h10;
  localparam logic [4:0] TEP_CAP_OFS = 5'h14;
  localparam logic [4:0] TEP_STAT_OFS = 5'h18;

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int TEP_CTRL_T0_CNT = 0;
  localparam int TEP_CTRL_T0_RUN = 1;
  localparam int TEP_CTRL_T1_CNT = 2;
  localparam int TEP_CTRL_T1_RUN = 3;
  localparam int TEP_CTRL_T2_MODE_LSB = 4;
  localparam int TEP_CTRL_T2_RUN = 8;
  localparam int TEP_STAT_CAPF = 0;
  localparam int TEP_STAT_EXRF = 1;
  localparam int TEP_STAT_OVF = 2;
  localparam int TEP_STAT_UP = 3;
  localparam int TEP_STAT_TIMER2_EXTERNAL_INPUT = 4;
  localparam int TEP_STAT_T2CLK = 5;
  localparam int TEP_STAT_INRST = 6;

  // ----------------------------------------------------------------------
  // Reset values, timing counts and pin indices.
  // ----------------------------------------------------------------------
  localparam logic [31:0] TEP_CTRL_RESET = 32'h0000_0000;
  localparam int TEP_RESET_HOLD_CYCLES = 64;
  localparam int TEP_PIN_W = 4;
  localparam int TEP_PIN_T0 = 0;
  localparam int TEP_PIN_T1 = 1;
  localparam int TEP_PIN_T2CLK = 2;
  localparam int TEP_PIN_TIMER2_EXTERNAL_INPUT = 3;

  // Timer 2 operating modes as held in the control register.
  typedef enum logic [2:0] {
    TEP_T2_STOP = 3'h0,
    TEP_T2_CAPTURE = 3'h1,
    TEP_T2_RELOAD = 3'h2,
    TEP_T2_UPDOWN = 3'h3,
    TEP_T2_CLKOUT = 3'h4
  } tep_t2_mode_e;

endpackage

// ==== core/tep_pin_sync.sv ====
`timescale 1ns/10ps
module tep_pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic ref_clk, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [WIDTH-1:0] pin_in, // Raw pin levels.
  output logic [WIDTH-1:0] level, // Synchronised levels.
  output logic [WIDTH-1:0] fall // One-cycle pulse per falling edge.
);

  // ----------------------------------------------------------------------
  // Per-pin two-stage synchroniser and edge detector.
  // ----------------------------------------------------------------------
  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      logic meta_reg;
      logic sync_reg;
      logic last_reg;

      // The first stage feeds only the second stage.
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          meta_reg <= 1'b1;
          sync_reg <= 1'b1;
          last_reg <= 1'b1;
        end else begin
          meta_reg <= pin_in[i];
          sync_reg <= meta_reg;
          last_reg <= sync_reg;
        end
      end

      assign level[i] = sync_reg;
      assign fall[i] = last_reg & ~sync_reg;
    end
  endgenerate

endmodule

// ==== core/tep_timer_pins.sv ====
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module tep_timer_pins
  import tep_pkg::*;
#(
  parameter int TW = 16,
  parameter int RESET_HOLD = TEP_RESET_HOLD_CYCLES
) (
  input wire logic ref_clk, // System clock, 100 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic wb_cyc_i, // Bus cycle.
  input wire logic wb_stb_i, // Bus strobe.
  input wire logic wb_we_i, // Write enable.
  input wire logic [TEP_ADR_W-1:0] wb_adr_i, // Byte address.
  input wire logic [3:0] wb_sel_i, // Byte lane selects.
  input wire logic [31:0] wb_dat_i, // Write data.
  output logic [31:0] wb_dat_o, // Read data.
  output logic wb_ack_o, // Acknowledge.
  input wire logic reset_pin, // Device reset pin, active high.
  input wire logic [1:0] timer01_count_input, // Timer 0 and 1 count pins.
  input wire logic timer2_clock_pin_i, // Timer 2 clock pin, input side.
  output logic timer2_clock_pin_o, // Timer 2 clock pin, output side.
  output logic timer2_clock_pin_oe, // Timer 2 clock pin output enable.
  input wire logic timer2_external_input, // Timer 2 external input pin.
  output logic device_in_reset // High while the reset pin holds reset.
);

  // ----------------------------------------------------------------------
  // Elaboration checks.
  // ----------------------------------------------------------------------
  generate
    if (TW < 2 || TW > 32) begin : g_bad_tw
      $error("TW must lie between 2 and 32.");
    end
    if (RESET_HOLD < 1) begin : g_bad_hold
      $error("RESET_HOLD must be at least 1.");
    end
  endgenerate

  localparam int HW = $clog2(RESET_HOLD + 1);
  localparam logic [HW-1:0] HOLD_DONE = HW'(RESET_HOLD);
  localparam logic [TW-1:0] T_ONES = {TW{1'b1}};
  localparam logic [TW-1:0] T_ZERO = {TW{1'b0}};
  localparam logic [TW-1:0] T_ONE = TW'(1);

  // ----------------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------------
  logic [HW-1:0] hold_cnt_reg;
  logic in_reset_reg;
  logic [31:0] ctrl_reg;
  logic [TW-1:0] t01_count_reg [2];
  logic [TW-1:0] t2_count_reg;
  logic [TW-1:0] t2_reload_reg;
  logic [TW-1:0] t2_capture_reg;
  logic capf_reg;
  logic exrf_reg;
  logic ovf_reg;
  logic clk_out_reg;
  logic clk_oe_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [TEP_PIN_W-1:0] pin_level;
  logic [TEP_PIN_W-1:0] pin_fall;
  logic take;
  logic wr_take;
  logic [1:0] wr_t01;
  logic [1:0] t01_counter_mode;
  logic [1:0] t01_run;
  tep_t2_mode_e t2_mode;
  logic t2_run;
  logic t2_tick;
  logic t2_up;
  logic t2_wrap_up;
  logic t2_wrap_down;
  logic [TW-1:0] t2_next;
  logic [31:0] stat_word;

  // Applies the byte lane selects to a register's old value.
  function automatic logic [31:0] merge(input logic [31:0] old_val,
                                        input logic [31:0] new_val,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_val[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------------
  tep_pin_sync #(
    .WIDTH(TEP_PIN_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in({timer2_external_input, timer2_clock_pin_i, timer01_count_input}),
    .level(pin_level),
    .fall(pin_fall)
  );

  // ----------------------------------------------------------------------
  // Reset pin qualification.
  // ----------------------------------------------------------------------

  // Counts cycles with the reset pin high; reset holds once the count is reached.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hold_cnt_reg <= '0;
    end else if (!reset_pin) begin
      hold_cnt_reg <= '0;
    end else if (hold_cnt_reg != HOLD_DONE) begin
      hold_cnt_reg <= hold_cnt_reg + HW'(1);
    end
  end

  // Internal reset asserts at the count and releases when the pin falls.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      in_reset_reg <= 1'b0;
    end else begin
      in_reset_reg <= reset_pin && (hold_cnt_reg == HOLD_DONE);
    end
  end

  // ----------------------------------------------------------------------
  // Bus slave: one wait state, every address acknowledged.
  // ----------------------------------------------------------------------

  // A request is taken on the edge where ack rises.
  assign take = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_take = take && wb_we_i;
  assign wr_t01[0] = wr_take && (wb_adr_i == TEP_T0_OFS);
  assign wr_t01[1] = wr_take && (wb_adr_i == TEP_T1_OFS);

  // Acknowledge for one cycle after each taken request.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= take;
    end
  end

  // Status word gathers flags and live pin state.
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[TEP_STAT_CAPF] = capf_reg;
    stat_word[TEP_STAT_EXRF] = exrf_reg;
    stat_word[TEP_STAT_OVF] = ovf_reg;
    stat_word[TEP_STAT_UP] = t2_up;
    stat_word[TEP_STAT_TIMER2_EXTERNAL_INPUT] = pin_level[TEP_PIN_TIMER2_EXTERNAL_INPUT];
    stat_word[TEP_STAT_T2CLK] = pin_level[TEP_PIN_T2CLK];
    stat_word[TEP_STAT_INRST] = in_reset_reg;
  end

  // Read data is registered with the ack; unmapped addresses read zero.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (take && !wb_we_i) begin
      unique case (wb_adr_i)
        TEP_CTRL_OFS: rdata_reg <= ctrl_reg;
        TEP_T0_OFS: rdata_reg <= 32'(t01_count_reg[0]);
        TEP_T1_OFS: rdata_reg <= 32'(t01_count_reg[1]);
        TEP_T2_OFS: rdata_reg <= 32'(t2_count_reg);
        TEP_RLD_OFS: rdata_reg <= 32'(t2_reload_reg);
        TEP_CAP_OFS: rdata_reg <= 32'(t2_capture_reg);
        TEP_STAT_OFS: rdata_reg <= stat_word;
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Control register; cleared by the qualified reset pin as well.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= TEP_CTRL_RESET;
    end else if (in_reset_reg) begin
      ctrl_reg <= TEP_CTRL_RESET;
    end else if (wr_take && (wb_adr_i == TEP_CTRL_OFS)) begin
      ctrl_reg <= merge(ctrl_reg, wb_dat_i, wb_sel_i) & 32'h0000_017F;
    end
  end

  // Reload register.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      t2_reload_reg <= T_ZERO;
    end else if (in_reset_reg) begin
      t2_reload_reg <= T_ZERO;
    end else if (wr_take && (wb_adr_i == TEP_RLD_OFS)) begin
      t2_reload_reg <= TW'(merge(32'(t2_reload_reg), wb_dat_i, wb_sel_i));
    end
  end

  // ----------------------------------------------------------------------
  // Timers 0 and 1.
  // ----------------------------------------------------------------------
  assign t01_counter_mode = {ctrl_reg[TEP_CTRL_T1_CNT], ctrl_reg[TEP_CTRL_T0_CNT]};
  assign t01_run = {ctrl_reg[TEP_CTRL_T1_RUN], ctrl_reg[TEP_CTRL_T0_RUN]};

  generate
    for (genvar i = 0; i < 2; i++) begin : g_t01
      // Counter mode steps on pin falls, timer mode on every clock.
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          t01_count_reg[i] <= T_ZERO;
        end else if (in_reset_reg) begin
          t01_count_reg[i] <= T_ZERO;
        end else if (wr_t01[i]) begin
          t01_count_reg[i] <= TW'(merge(32'(t01_count_reg[i]), wb_dat_i, wb_sel_i));
        end else if (t01_run[i] && (!t01_counter_mode[i] || pin_fall[i])) begin
          t01_count_reg[i] <= t01_count_reg[i] + T_ONE;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Timer 2.
  // ----------------------------------------------------------------------
  assign t2_mode = tep_t2_mode_e'(ctrl_reg[TEP_CTRL_T2_MODE_LSB +: 3]);
  assign t2_run = ctrl_reg[TEP_CTRL_T2_RUN];

  // Direction follows the external input only in up-down mode.
  assign t2_up = (t2_mode != TEP_T2_UPDOWN) || pin_level[TEP_PIN_TIMER2_EXTERNAL_INPUT];

  // Tick source: clock pin falls in capture mode, system clock in reload, up-down and clock-out modes, no tick when stopped.
  always_comb begin
    unique case (t2_mode)
      TEP_T2_CAPTURE: t2_tick = t2_run && pin_fall[TEP_PIN_T2CLK];
      TEP_T2_RELOAD, TEP_T2_UPDOWN, TEP_T2_CLKOUT: t2_tick = t2_run;
      default: t2_tick = 1'b0;
    endcase
  end

  assign t2_wrap_up = t2_tick && t2_up && (t2_count_reg == T_ONES);
  assign t2_wrap_down = t2_tick && !t2_up && (t2_count_reg == t2_reload_reg);

  // Next count on a tick: up wraps to reload (zero in capture), down to all ones.
  always_comb begin
    if (t2_wrap_up) begin
      t2_next = (t2_mode == TEP_T2_CAPTURE) ? T_ZERO : t2_reload_reg;
    end else if (t2_wrap_down) begin
      t2_next = T_ONES;
    end else if (t2_up) begin
      t2_next = t2_count_reg + T_ONE;
    end else begin
      t2_next = t2_count_reg - T_ONE;
    end
  end

  // Count register; a pin reload beats a tick, a bus write beats both.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      t2_count_reg <= T_ZERO;
    end else if (in_reset_reg) begin
      t2_count_reg <= T_ZERO;
    end else if (wr_take && (wb_adr_i == TEP_T2_OFS)) begin
      t2_count_reg <= TW'(merge(32'(t2_count_reg), wb_dat_i, wb_sel_i));
    end else if ((t2_mode == TEP_T2_RELOAD) && pin_fall[TEP_PIN_TIMER2_EXTERNAL_INPUT]) begin
      t2_count_reg <= t2_reload_reg;
    end else if (t2_tick) begin
      t2_count_reg <= t2_next;
    end
  end

  // Capture register takes the live count on an external input fall in capture mode.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      t2_capture_reg <= T_ZERO;
    end else if (in_reset_reg) begin
      t2_capture_reg <= T_ZERO;
    end else if ((t2_mode == TEP_T2_CAPTURE) && pin_fall[TEP_PIN_TIMER2_EXTERNAL_INPUT]) begin
      t2_capture_reg <= t2_count_reg;
    end
  end

  // Sticky event flags, cleared by writing one; a new event beats the clear.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      capf_reg <= 1'b0;
      exrf_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else if (in_reset_reg) begin
      capf_reg <= 1'b0;
      exrf_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else begin
      if ((t2_mode == TEP_T2_CAPTURE) && pin_fall[TEP_PIN_TIMER2_EXTERNAL_INPUT]) begin
        capf_reg <= 1'b1;
      end else if (wr_take && (wb_adr_i == TEP_STAT_OFS) && wb_sel_i[0]
                   && wb_dat_i[TEP_STAT_CAPF]) begin
        capf_reg <= 1'b0;
      end
      if ((t2_mode == TEP_T2_RELOAD) && pin_fall[TEP_PIN_TIMER2_EXTERNAL_INPUT]) begin
        exrf_reg <= 1'b1;
      end else if (wr_take && (wb_adr_i == TEP_STAT_OFS) && wb_sel_i[0]
                   && wb_dat_i[TEP_STAT_EXRF]) begin
        exrf_reg <= 1'b0;
      end
      if (t2_wrap_up || t2_wrap_down) begin
        ovf_reg <= 1'b1;
      end else if (wr_take && (wb_adr_i == TEP_STAT_OFS) && wb_sel_i[0]
                   && wb_dat_i[TEP_STAT_OVF]) begin
        ovf_reg <= 1'b0;
      end
    end
  end

  // Clock-out: the pin toggles on every overflow and is driven only in that mode.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clk_out_reg <= 1'b0;
      clk_oe_reg <= 1'b0;
    end else if (in_reset_reg) begin
      clk_out_reg <= 1'b0;
      clk_oe_reg <= 1'b0;
    end else begin
      clk_oe_reg <= (t2_mode == TEP_T2_CLKOUT);
      if (t2_mode != TEP_T2_CLKOUT) begin
        clk_out_reg <= 1'b0;
      end else if (t2_wrap_up) begin
        clk_out_reg <= ~clk_out_reg;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, each straight from a flip-flop.
  // ----------------------------------------------------------------------
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign timer2_clock_pin_o = clk_out_reg;
  assign timer2_clock_pin_oe = clk_oe_reg;
  assign device_in_reset = in_reset_reg;

endmodule

// ==== dv/tep_timer_pins_assertions.sv ====
`timescale 1ns/10ps
module tep_timer_pins_assertions
  import tep_pkg::*;
#(
  parameter int TW = 16,
  parameter int RESET_HOLD = TEP_RESET_HOLD_CYCLES
) (
  input wire logic ref_clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic wb_cyc_i, // Cycle.
  input wire logic wb_stb_i, // Strobe.
  input wire logic wb_we_i, // Write.
  input wire logic [TEP_ADR_W-1:0] wb_adr_i, // Address.
  input wire logic [31:0] wb_dat_o, // Read data.
  input wire logic wb_ack_o, // Acknowledge.
  input wire logic reset_pin, // Reset pin.
  input wire logic timer2_clock_pin_oe, // Clock pin enable.
  input wire logic timer2_external_input, // External input.
  input wire logic device_in_reset // In reset.
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  logic take;
  logic rd_take;
  logic wr_take;
  int hold_reg;
  // Request decode as seen by the slave.
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_take = take && !wb_we_i;
  assign wr_take = take && wb_we_i;
  // Counts consecutive edges with the reset pin high, saturating.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hold_reg <= 0;
    end else if (!reset_pin) begin
      hold_reg <= 0;
    end else if (hold_reg < RESET_HOLD) begin
      hold_reg <= hold_reg + 1;
    end
  end
  a_ack_follows: assert property (take |=> wb_ack_o) else $error("ack missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_uncaused: assert property (!take |=> !wb_ack_o) else $error("ack without request");
  a_unmapped_zero: assert property (rd_take && wb_adr_i > 5'h18 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_spare: assert property (rd_take && wb_adr_i == TEP_CTRL_OFS
    |=> wb_dat_o[31:9] == 23'h0 && !wb_dat_o[7]) else $error("spare control bits set");
  a_data_holds: assert property (!rd_take |=> $stable(wb_dat_o)) else $error("read data moved");
  a_reset_early: assert property (hold_reg < RESET_HOLD |=> !device_in_reset)
    else $error("reset entered early");
  a_reset_entry: assert property (reset_pin && hold_reg >= RESET_HOLD |=> device_in_reset)
    else $error("reset not entered");
  a_reset_exit: assert property (!reset_pin |=> !device_in_reset)
    else $error("reset not left");
  a_oe_cause: assert property ($changed(timer2_clock_pin_oe) |-> $past(wr_take) ||
    $past(wr_take, 2) || $past(device_in_reset) || $past(device_in_reset, 2))
    else $error("clock pin enable moved alone");
  a_ext_sync: assert property (rd_take && wb_adr_i == TEP_STAT_OFS && !$past(rst, 2)
    |=> wb_dat_o[TEP_STAT_TIMER2_EXTERNAL_INPUT] == $past(timer2_external_input, 3)) else $error("sync level");
  c_clock_out: cover property ($rose(timer2_clock_pin_oe));
  c_reset_held: cover property ($rose(device_in_reset));
  c_unmapped: cover property (rd_take && wb_adr_i > 5'h18);
endmodule
bind tep_timer_pins tep_timer_pins_assertions #(.TW(TW), .RESET_HOLD(RESET_HOLD)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .reset_pin(reset_pin),
  .timer2_clock_pin_oe(timer2_clock_pin_oe), .timer2_external_input(timer2_external_input),
  .device_in_reset(device_in_reset));

// ==== dv/tep_pin_source.sv ====
`timescale 1ns/10ps
module tep_pin_source (
  input wire logic ref_clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic [3:0] fall_req, // Requests one low pulse per pin.
  input wire logic [3:0] lvl, // Idle level per pin.
  input wire logic slow, // Long low phase when set.
  input wire logic [7:0] rst_len, // Reset pin high time in cycles.
  input wire logic rst_go, // Starts a reset pin pulse.
  output logic [3:0] pins, // Pin levels.
  output logic reset_pin, // Device reset pin.
  output logic busy // A pulse is in progress.
);
  int ph [4];
  int rcnt;
  // Each pulse is low two or six cycles, then high three so both levels are seen.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ph <= '{default: 0};
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (fall_req[i]) begin
          ph[i] <= slow ? 9 : 5;
        end else if (ph[i] > 0) begin
          ph[i] <= ph[i] - 1;
        end
      end
    end
  end
  // The reset pin stays high for exactly the requested number of edges.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rcnt <= 0;
    end else if (rst_go) begin
      rcnt <= int'(rst_len);
    end else if (rcnt > 0) begin
      rcnt <= rcnt - 1;
    end
  end
  // Pins rest at their idle level from lvl unless a pulse drives them low.
  always_comb begin
    busy = (rcnt > 0);
    for (int i = 0; i < 4; i++) begin
      pins[i] = (ph[i] > 3) ? 1'b0 : lvl[i];
      busy = busy | (ph[i] > 0);
    end
  end
  assign reset_pin = (rcnt > 0);
endmodule

// ==== dv/tep_timer_pins_tb.sv ====
`timescale 1ns/10ps
module tep_timer_pins_tb
  import tep_pkg::*;
();
  logic ref_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, slow, rst_go, busy;
  logic reset_pin, pin_o, pin_oe, t2_wire, in_rst, prev;
  logic [4:0] wb_adr_i;
  logic [3:0] wb_sel_i, fall_req, lvl, pins;
  logic [31:0] wb_dat_i, wb_dat_o, rd_val, seed, s0, r, a;
  logic [7:0] rst_len;
  int bad_count, checks, cyc_n, n0, n1, n;
  // The clock pin wire follows whichever side drives it.
  assign t2_wire = pin_oe ? pin_o : pins[TEP_PIN_T2CLK];
  tep_timer_pins DUT (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .reset_pin(reset_pin),
    .timer01_count_input(pins[1:0]), .timer2_clock_pin_i(t2_wire), .timer2_clock_pin_o(pin_o),
    .timer2_clock_pin_oe(pin_oe), .timer2_external_input(pins[TEP_PIN_TIMER2_EXTERNAL_INPUT]),
    .device_in_reset(in_rst));
  tep_pin_source src (.ref_clk(ref_clk), .rst(rst), .fall_req(fall_req), .lvl(lvl),
    .slow(slow), .rst_len(rst_len), .rst_go(rst_go), .pins(pins), .reset_pin(reset_pin),
    .busy(busy));
  // Clock generation.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] wrap16(input logic [31:0] v);
    return {16'h0000, v[15:0]};
  endfunction
  function automatic logic [31:0] ctrl_word(input logic [2:0] m);
    return {23'h0, 1'b1, 1'b0, m, 4'h0};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle; read data is taken at the acknowledge edge.
  task automatic bus(input logic w, input logic [4:0] ad, input logic [31:0] d);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= ad;
    wb_dat_i <= d;
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    rd_val = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic pulse(input int i, input int k);
    repeat (k) begin
      @(posedge ref_clk);
      fall_req[i] <= 1'b1;
      slow <= seed[0];
      seed = lfsr(seed);
      @(posedge ref_clk);
      fall_req[i] <= 1'b0;
      do @(posedge ref_clk); while (busy);
    end
  endtask
  task automatic rpulse(input logic [7:0] len);
    @(posedge ref_clk);
    rst_len <= len;
    rst_go <= 1'b1;
    @(posedge ref_clk);
    rst_go <= 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Cuts a hung run short.
  always @(posedge ref_clk) begin
    cyc_n++;
    if (cyc_n > 20000) begin
      bad_count++;
      summarize();
    end
  end
  // Main sequence.
  initial begin
    {rst, wb_cyc_i, wb_stb_i, wb_we_i, slow, rst_go} = 6'h20;
    {wb_adr_i, wb_dat_i, fall_req, rst_len} = '0;
    wb_sel_i = 4'hF;
    lvl = 4'hF;
    seed = 32'h79F9;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    bus(0, TEP_CTRL_OFS, 0);
    chk(rd_val, TEP_CTRL_RESET);
    bus(0, 5'h1C, 0);
    chk(rd_val, 32'h0);
    seed = lfsr(seed);
    bus(1, TEP_CTRL_OFS, seed);
    bus(0, TEP_CTRL_OFS, 0);
    chk(rd_val, seed & 32'h0000_017F);
    $display("register test done");
    n0 = 1 + int'(seed[3:0]);
    n1 = 1 + int'(seed[7:4]);
    s0 = wrap16(seed);
    bus(1, TEP_CTRL_OFS, 32'h0000_000F);
    bus(1, TEP_T0_OFS, s0);
    bus(1, TEP_T1_OFS, 32'h0000_FFFF);
    pulse(TEP_PIN_T0, n0);
    pulse(TEP_PIN_T1, n1);
    bus(0, TEP_T0_OFS, 0);
    chk(rd_val, wrap16(s0 + n0));
    bus(0, TEP_T1_OFS, 0);
    chk(rd_val, wrap16(32'h0000_FFFF + n1));
    bus(1, TEP_CTRL_OFS, 32'h0000_0002);
    bus(0, TEP_T0_OFS, 0);
    a = rd_val;
    bus(0, TEP_T0_OFS, 0);
    chk(wrap16(rd_val - a), 32'h3);
    $display("counter test done");
    bus(1, TEP_T2_OFS, 32'h0000_1230);
    bus(1, TEP_CTRL_OFS, ctrl_word(TEP_T2_CAPTURE));
    pulse(TEP_PIN_T2CLK, 3);
    chk(pin_oe, 1'b0);
    bus(0, TEP_T2_OFS, 0);
    chk(rd_val, 32'h0000_1233);
    pulse(TEP_PIN_TIMER2_EXTERNAL_INPUT, 1);
    bus(0, TEP_CAP_OFS, 0);
    chk(rd_val, 32'h0000_1233);
    bus(0, TEP_STAT_OFS, 0);
    chk(rd_val[TEP_STAT_CAPF], 1'b1);
    bus(1, TEP_STAT_OFS, 32'h0000_0001);
    bus(0, TEP_STAT_OFS, 0);
    chk(rd_val[TEP_STAT_CAPF], 1'b0);
    $display("capture test done");
    r = 32'h0000_8000 + seed[7:0];
    bus(1, TEP_RLD_OFS, r);
    bus(1, TEP_T2_OFS, 32'h0000_0100);
    bus(1, TEP_CTRL_OFS, ctrl_word(TEP_T2_RELOAD));
    pulse(TEP_PIN_TIMER2_EXTERNAL_INPUT, 1);
    bus(0, TEP_T2_OFS, 0);
    chk(32'(rd_val[15:0] - r[15:0] < 16'h0018), 32'h1);
    bus(0, TEP_STAT_OFS, 0);
    chk(rd_val[TEP_STAT_EXRF], 1'b1);
    $display("reload test done");
    bus(1, TEP_T2_OFS, 32'h0000_4000);
    bus(1, TEP_CTRL_OFS, ctrl_word(TEP_T2_UPDOWN));
    for (int d = 1; d >= 0; d--) begin
      @(posedge ref_clk);
      lvl <= {d[0], 3'h7};
      repeat (3) @(posedge ref_clk);
      bus(0, TEP_STAT_OFS, 0);
      chk(rd_val[TEP_STAT_UP], d[0]);
      bus(0, TEP_T2_OFS, 0);
      a = rd_val;
      bus(0, TEP_T2_OFS, 0);
      chk(wrap16(rd_val - a), d ? 32'h3 : 32'h0000_FFFD);
    end
    lvl <= 4'hF;
    $display("up-down test done");
    bus(1, TEP_RLD_OFS, 32'h0000_FFF0);
    bus(1, TEP_T2_OFS, 32'h0000_FFF0);
    bus(1, TEP_CTRL_OFS, ctrl_word(TEP_T2_CLKOUT));
    @(posedge ref_clk);
    chk(pin_oe, 1'b1);
    prev = pin_o;
    do @(posedge ref_clk); while (pin_o === prev);
    prev = pin_o;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pin_o === prev);
    chk(n, 16);
    bus(0, TEP_STAT_OFS, 0);
    chk(rd_val[TEP_STAT_T2CLK], pin_o);
    $display("clock-out test done");
    rpulse(8'h3F);
    do @(posedge ref_clk); while (busy);
    chk(in_rst, 1'b0);
    rpulse(8'h48);
    do @(posedge ref_clk); while (!in_rst);
    bus(1, TEP_CTRL_OFS, 32'h0000_010F);
    bus(0, TEP_CTRL_OFS, 0);
    chk(rd_val, TEP_CTRL_RESET);
    chk(pin_oe, 1'b0);
    do @(posedge ref_clk); while (busy);
    repeat (2) @(posedge ref_clk);
    chk(in_rst, 1'b0);
    $display("reset pin test done");
    summarize();
  end
endmodule
